// *** design/ep_buf_regs.svh ***
// Register map and field layout of the endpoint buffer control block.
// Assumes inclusion by bare name from the package and design files.
`ifndef EP_BUF_REGS_SVH
`define EP_BUF_REGS_SVH
`define EPBUF_CTRL_OFFSET 12'h228
`define EPBUF_INDEX_OFFSET 12'h22C
`define EPBUF_CTRL_RESET 8'h00
`define EPBUF_INDEX_RESET 8'h20
`define EPBUF_BIT_STALL 0
`define EPBUF_BIT_STATUS 1
`define EPBUF_BIT_DATA_STAGE_ENABLE 2
`define EPBUF_BIT_VALIDATE 3
`define EPBUF_BIT_CLEAR 4
`define EPBUF_IDX_DIR 0
`define EPBUF_IDX_SETUP 5
`define EPBUF_NUM_EP 16
`endif

// *** design/ep_buf_pkg.sv ***
// Types shared by the endpoint buffer control block and its bench.
// Assumes ep_buf_regs.svh sits beside it.
`include "ep_buf_regs.svh"
package ep_buf_pkg;
    // One event reported by the USB protocol engine for an endpoint
    typedef struct packed {
        logic valid;
        logic [3:0] ep_num;
        logic dir_in;
    } ep_event_t;

    // Per endpoint command pulses towards the buffer logic
    typedef struct packed {
        logic [15:0] rx_clear;
        logic [15:0] tx_validate;
    } buf_cmd_t;

    typedef enum logic [1:0] {
        RESP_NAK,
        RESP_ACK,
        RESP_STALL
    } resp_t;
endpackage

// *** design/ep_buf_ctrl.sv ***
// Endpoint buffer control register with its endpoint index register.
// Assumes a synchronous byte register port and a USB protocol engine on clk.
// Rules from the document for this block and its software
// R1: Index selects endpoint for each control access
// R2: Upper bits written zero by software
// R3: Clear bit empties selected receive buffer only
// R4: Receive buffer auto clears after full read
// R5: Double buffer needs clear command twice
// R6: Validate bit readies selected transmit FIFO
// R7: Auto validate when count reaches max packet
// R8: Control OUT data stage NAKed without enable
// R9: Control IN sets enable before filling FIFO
// R10: Enable clears after data stage acknowledge
// R11: Enable bit always reads back zero
// R12: No data stage: status bit straight away
// R13: Status stage NAK unless status bit set
// R14: Status bit only for control endpoint
// R15: Status bit clears on SETUP, no interrupt
// R16: Status bit clears when status packet acknowledged
// R17: Data transfers finish before status bit set
// R18: Stall bit stalls selected non-isochronous endpoint
// R19: Stall keeps toggle; re-enable resets it
// R20: Index holds setup select, number, direction
// R21: Each clear or validate write acts once
`timescale 1ns/1ps
`include "ep_buf_regs.svh"
module ep_buf_ctrl
    import ep_buf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_reset,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] ep_isochronous,
    input wire logic [15:0] rx_read_done,
    input wire logic [15:0] tx_count_full,
    input wire ep_event_t setup_token,
    input wire ep_event_t data_acked,
    input wire ep_event_t status_acked,
    input wire logic status_stage,
    input wire logic ctrl_data_stage,
    input wire logic ctrl_dir_in,
    output logic [15:0] rx_clear_pulse,
    output logic [15:0] tx_validate_pulse,
    output logic [15:0] stall_out,
    output logic [15:0] stall_in,
    output resp_t ctrl_resp,
    output logic status_send_zlp,
    output logic [7:0] index_out
);
    logic [7:0] index_reg;
    logic [15:0] stall_out_reg;
    logic [15:0] stall_in_reg;
    logic data_stage_enable_reg;
    logic status_reg;
    buf_cmd_t cmd_next;
    logic [3:0] sel_ep;
    logic sel_in;
    logic sel_ctrl;
    logic wr_ctrl;
    logic wr_index;
    logic [7:0] ctrl_view;

    assign sel_ep = index_reg[4:1];  // [R20]
    assign sel_in = index_reg[`EPBUF_IDX_DIR];  // [R20]
    assign sel_ctrl = (sel_ep == 4'h0) && !index_reg[`EPBUF_IDX_SETUP];
    assign wr_ctrl = reg_wr && (reg_addr == `EPBUF_CTRL_OFFSET);
    assign wr_index = reg_wr && (reg_addr == `EPBUF_INDEX_OFFSET);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_reg <= `EPBUF_INDEX_RESET;
        end else if (bus_reset) begin
            index_reg <= `EPBUF_INDEX_RESET;
        end else if (wr_index) begin
            index_reg <= {2'h0, reg_wdata[5:0]};  // [R1]
        end
    end

    // Commands are one-cycle pulses per write, never held levels
    always_comb begin
        cmd_next.rx_clear = rx_read_done;  // [R4]
        cmd_next.tx_validate = tx_count_full;  // [R7]
        if (wr_ctrl && reg_wdata[`EPBUF_BIT_CLEAR] && !sel_in) begin
            cmd_next.rx_clear[sel_ep] = 1'b1;  // [R3] [R5] [R21]
        end
        if (wr_ctrl && reg_wdata[`EPBUF_BIT_VALIDATE] && sel_in) begin
            cmd_next.tx_validate[sel_ep] = 1'b1;  // [R6] [R21]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_clear_pulse <= 16'h0000;
            tx_validate_pulse <= 16'h0000;
        end else if (bus_reset) begin
            rx_clear_pulse <= 16'h0000;
            tx_validate_pulse <= 16'h0000;
        end else begin
            rx_clear_pulse <= cmd_next.rx_clear;
            tx_validate_pulse <= cmd_next.tx_validate;
        end
    end

    // Stall is a level per endpoint and direction; toggle state lives elsewhere
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stall_out_reg <= 16'h0000;
            stall_in_reg <= 16'h0000;
        end else if (bus_reset) begin
            stall_out_reg <= 16'h0000;
            stall_in_reg <= 16'h0000;
        end else if (wr_ctrl && !ep_isochronous[sel_ep]) begin  // [R18]
            if (sel_in) begin
                stall_in_reg[sel_ep] <= reg_wdata[`EPBUF_BIT_STALL];  // [R18] [R19]
            end else begin
                stall_out_reg[sel_ep] <= reg_wdata[`EPBUF_BIT_STALL];  // [R18] [R19]
            end
        end
    end

    // A software set in the same cycle as an acknowledge wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_stage_enable_reg <= 1'b0;
        end else if (bus_reset) begin
            data_stage_enable_reg <= 1'b0;
        end else if (wr_ctrl && sel_ctrl && reg_wdata[`EPBUF_BIT_DATA_STAGE_ENABLE]) begin
            data_stage_enable_reg <= 1'b1;  // [R8] [R9]
        end else if (data_acked.valid && data_acked.ep_num == 4'h0) begin
            data_stage_enable_reg <= 1'b0;  // [R10]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_reg <= 1'b0;
        end else if (bus_reset) begin
            status_reg <= 1'b0;
        end else if (wr_ctrl && sel_ctrl) begin
            status_reg <= reg_wdata[`EPBUF_BIT_STATUS];  // [R12] [R14] [R17]
        end else if (setup_token.valid && setup_token.ep_num == 4'h0) begin
            status_reg <= 1'b0;  // [R15]
        end else if (status_acked.valid && status_acked.ep_num == 4'h0) begin
            status_reg <= 1'b0;  // [R16]
        end
    end

    // Response for the control endpoint; stall overrides ctrl_resp, while status_send_zlp ignores it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_resp <= RESP_NAK;
            status_send_zlp <= 1'b0;
        end else begin
            status_send_zlp <= status_stage && status_reg && ctrl_dir_in;  // [R13]
            if ((ctrl_dir_in ? stall_in_reg[0] : stall_out_reg[0])) begin
                ctrl_resp <= RESP_STALL;
            end else if (status_stage) begin
                ctrl_resp <= status_reg ? RESP_ACK : RESP_NAK;  // [R13]
            end else if (ctrl_data_stage) begin
                ctrl_resp <= data_stage_enable_reg ? RESP_ACK : RESP_NAK;  // [R8]
            end else begin
                ctrl_resp <= RESP_NAK;
            end
        end
    end

    // Data stage enable reads as zero; command bits are not stored
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`EPBUF_BIT_STALL] = sel_in ? stall_in_reg[sel_ep] : stall_out_reg[sel_ep];
        ctrl_view[`EPBUF_BIT_STATUS] = sel_ctrl & status_reg;
        ctrl_view[`EPBUF_BIT_DATA_STAGE_ENABLE] = 1'b0;  // [R11]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == `EPBUF_CTRL_OFFSET) begin
            reg_rdata <= ctrl_view;
        end else if (reg_rd && reg_addr == `EPBUF_INDEX_OFFSET) begin
            reg_rdata <= index_reg;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign stall_out = stall_out_reg;
    assign stall_in = stall_in_reg;
    assign index_out = index_reg;
endmodule

// *** bench/ep_buf_props.sv ***
// Port checker for the buffer control block.
// Assumes it is bound onto ep_buf_ctrl.
`timescale 1ns/1ps
module ep_buf_props
    import ep_buf_pkg::*;
(
    input wire logic clk, rst, bus_reset, reg_wr, reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata, index_out,
    input wire logic [15:0] ep_isochronous, rx_read_done, tx_count_full,
    input wire logic [15:0] rx_clear_pulse, tx_validate_pulse, stall_out,
    input wire ep_event_t setup_token, status_acked,
    input wire logic status_send_zlp
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst || bus_reset);
    wire logic wc = reg_wr && reg_addr == 12'h228;
    wire logic dir = index_out[0];
    wire logic [3:0] ep = index_out[4:1];
    chk_clear_one: assert property (
        wc && reg_wdata[4] && !dir |=> rx_clear_pulse[$past(ep)]) else $error("no clear");
    chk_validate_one: assert property (
        wc && reg_wdata[3] && dir |=> tx_validate_pulse[$past(ep)]) else $error("no valid");
    chk_auto_clear: assert property (
        |rx_read_done |=> &(rx_clear_pulse | ~$past(rx_read_done))) else $error("no auto clr");
    chk_auto_valid: assert property (
        |tx_count_full |=> &(tx_validate_pulse | ~$past(tx_count_full))) else $error("no auto");
    chk_enable_reads_zero: assert property (
        reg_rd && reg_addr == 12'h228 |=> !reg_rdata[2]) else $error("enable read");
    chk_stall_sets: assert property (
        wc && reg_wdata[0] && !dir && !ep_isochronous[ep] |=> stall_out[$past(ep)])
        else $error("no stall");
    chk_iso_no_stall: assert property (
        wc && ep_isochronous[ep] |=> $stable(stall_out)) else $error("iso stall");
    chk_status_clears: assert property (
        (setup_token.valid || status_acked.valid) && !reg_wr |=> !reg_wr ##1 !status_send_zlp)
        else $error("status kept");
    cover property (wc && reg_wdata[4]);
    cover property (|tx_count_full);
    cover property (status_acked.valid);
endmodule
bind ep_buf_ctrl ep_buf_props i_props (.*);

// *** bench/usb_host_model.sv ***
// Host side of ep0 control transfers as seen by the engine.
// Assumes the bench calls its tasks off the clock edge.
`timescale 1ns/1ps
module usb_host_model
    import ep_buf_pkg::*;
(
    input wire logic clk,
    output ep_event_t setup_token,
    output ep_event_t status_acked,
    output logic status_stage
);
    initial begin
        setup_token = '0;
        status_acked = '0;
        status_stage = 1'b0;
    end
    task automatic stage(input logic on);
        @(posedge clk);
        status_stage <= on;
    endtask
    // One-cycle SETUP or status handshake
    task automatic hs(input logic is_setup);
        @(posedge clk);
        if (is_setup) setup_token <= 6'h20;
        else status_acked <= 6'h21;
        @(posedge clk);
        setup_token <= '0;
        status_acked <= '0;
    endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the buffer control block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module tb;
    import ep_buf_pkg::*;
    logic clk = 0, rst = 1, bus_reset = 0, reg_wr = 0, reg_rd = 0, ctrl_data_stage = 0;
    logic [11:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, index_out;
    logic [15:0] iso = '0, rdn = '0, cfull = '0, rx_clr, tx_val, stall_out, stall_in;
    ep_event_t setup_token, status_acked;
    logic status_stage, zlp;
    logic dir_in = 0;
    ep_event_t dack = '0;
    resp_t ctrl_resp;
    int fails = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    usb_host_model i_host (.clk, .setup_token, .status_acked, .status_stage);
    ep_buf_ctrl i_dut (.clk, .rst, .bus_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .ep_isochronous(iso), .rx_read_done(rdn), .tx_count_full(cfull),
        .setup_token, .data_acked(dack), .status_acked, .status_stage, .ctrl_data_stage,
        .ctrl_dir_in(dir_in), .rx_clear_pulse(rx_clr), .tx_validate_pulse(tx_val), .stall_out,
        .stall_in, .ctrl_resp, .status_send_zlp(zlp), .index_out);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(exp));
    endtask
    task automatic t_buf;
        rd(12'h22C, 8'h20);
        wr(12'h22C, 8'h06);
        wr(12'h228, 8'h18);
        chk(rx_clr, 16'h0008);
        chk(tx_val, 16'h0000);
        wr(12'h228, 8'h10);
        chk(rx_clr, 16'h0008);
        wr(12'h22C, 8'h07);
        wr(12'h228, 8'h18);
        chk(tx_val, 16'h0008);
        @(posedge clk) #1 chk(tx_val, 16'h0000);
        @(posedge clk) {rdn, cfull} <= 32'h0004_8000;
        @(posedge clk) {rdn, cfull} <= '0;
        #1 chk(rx_clr, 16'h0004);
        chk(tx_val, 16'h8000);
    endtask
    task automatic t_stall;
        wr(12'h22C, 8'h05);
        @(posedge clk) iso <= 16'h0004;
        wr(12'h228, 8'h01);
        chk(stall_in, 16'h0000);
        @(posedge clk) iso <= '0;
        wr(12'h228, 8'h01);
        chk(stall_in, 16'h0004);
        chk(stall_out, 16'h0000);
        @(posedge clk) bus_reset <= 1'b1;
        @(posedge clk) bus_reset <= 1'b0;
        rd(12'h22C, 8'h20);
        chk(stall_in, 16'h0000);
    endtask
    task automatic t_ctrl;
        wr(12'h22C, 8'h00);
        @(posedge clk) ctrl_data_stage <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(16'(ctrl_resp), 16'(RESP_NAK));
        wr(12'h228, 8'h04);
        @(posedge clk) #1 chk(16'(ctrl_resp), 16'(RESP_ACK));
        rd(12'h228, 8'h00);
        @(posedge clk) dack <= 6'h20;
        @(posedge clk) dack <= '0;
        @(posedge clk) #1 chk(16'(ctrl_resp), 16'(RESP_NAK));
        @(posedge clk) ctrl_data_stage <= 1'b0;
        dir_in <= 1'b1;
        i_host.stage(1'b1);
        repeat (2) @(posedge clk);
        #1 chk(16'(ctrl_resp), 16'(RESP_NAK));
        wr(12'h228, 8'h02);
        @(posedge clk) #1 chk(16'(ctrl_resp), 16'(RESP_ACK));
        chk(16'(zlp), 16'h0001);
        i_host.hs(1'b0);
        @(posedge clk) #1 chk(16'(zlp), 16'h0000);
        wr(12'h228, 8'h02);
        @(posedge clk) #1 chk(16'(zlp), 16'h0001);
        i_host.hs(1'b1);
        @(posedge clk) #1 chk(16'(zlp), 16'h0000);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_buf();
        t_stall();
        t_ctrl();
        tally_and_finish();
    end
    initial begin
        #100us;
        fails++;
        tally_and_finish();
    end
endmodule
